// >>> design/supervisor_pkg.sv
// Package for the supply supervisor and watchdog block.
// Assumes a single 50 MHz clock; analog outcomes arrive as flags.
package supervisor_pkg;

    // Clock rate in Hz
    localparam int unsigned CLOCK_HZ = 50000000;

    // Reset pulse interval, in milliseconds as printed
    localparam int unsigned RESET_PULSE_MS = 200;
    // Watchdog timeout, in tenths of a second (1.6 s)
    localparam int unsigned WATCHDOG_TIMEOUT_DS = 16;
    // Shortest service pulse that must be seen, in ns
    localparam int unsigned MIN_PULSE_NS = 50;

    // Least time rounds up: cycles for the reset pulse
    localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_MS * (CLOCK_HZ / 1000) + 0) / 1;
    // Longest time rounds down: cycles for the watchdog timeout
    localparam int unsigned WATCHDOG_CYCLES = WATCHDOG_TIMEOUT_DS * (CLOCK_HZ / 10);
    // Cycles in the shortest pulse (rounded down, at least one)
    localparam int unsigned MIN_PULSE_CYCLES =
        ((MIN_PULSE_NS * (CLOCK_HZ / 1000000)) / 1000 < 1) ? 1 : (MIN_PULSE_NS * (CLOCK_HZ / 1000000)) / 1000;

    // Depth of the pin synchroniser
    localparam int unsigned SYNC_STAGES = 3;

    // Reset-pulse sequencer states
    typedef enum logic [1:0] {
        HOLD_LOW,
        TIMING,
        RELEASED
    } reset_state_type;

    // Analog comparator outcomes as digital flags
    typedef struct packed {
        logic below_threshold;
        logic powerfail_below_ref;
        logic backup_higher;
        logic service_floating;
    } analog_flags_type;

    // Outputs toward the supervised system
    typedef struct packed {
        logic reset_n;
        logic reset;
        logic powerfail_flag;
        logic ram_on_backup;
    } supervisor_out_type;

endpackage : supervisor_pkg

// >>> design/pin_sync.sv
// Synchroniser for pins arriving from outside the clock domain.
// Assumes clock_i free-running; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync;

    // Accept a new level only when the two later stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_sync[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_o[i];
        end
    end

    // Stage 1 feeds only stage 2, avoiding metastable fan-out
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_o <= '0;
        end else if (enable_i) begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_o <= next_sync;
        end
    end

endmodule : pin_sync

// >>> design/supply_supervisor_watchdog_reset.sv
// Supply supervisor: timed reset, watchdog, power-fail flag, RAM supply select.
// Assumes analog comparators outside deliver flags; one 50 MHz clock.
`timescale 1ns/1ps
module supply_supervisor_watchdog_reset #(
    parameter int unsigned RESET_CYCLES = supervisor_pkg::RESET_PULSE_CYCLES,
    parameter int unsigned WATCHDOG_LIMIT = supervisor_pkg::WATCHDOG_CYCLES
) (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clock_enable_i,
    // Analog comparator flags, asynchronous
    input wire logic supply_below_threshold_i,
    input wire logic powerfail_sense_input_i,
    input wire logic backup_supply_input_i,
    input wire logic service_floating_i,
    // Watchdog service pin from the processor
    input wire logic watchdog_service_input_i,
    // Outputs toward the system
    output logic reset_n_o,
    output logic reset_o,
    output logic powerfail_flag_output_o,
    output logic ram_on_backup_o,
    output logic watchdog_timeout_o
);

    localparam int unsigned RESET_W = (RESET_CYCLES > 1) ? $clog2(RESET_CYCLES + 1) : 1;
    localparam int unsigned WD_W = (WATCHDOG_LIMIT > 1) ? $clog2(WATCHDOG_LIMIT + 1) : 1;

    supervisor_pkg::analog_flags_type flags_raw;
    supervisor_pkg::analog_flags_type flags;
    logic service_sync;
    logic [4:0] sync_out;

    supervisor_pkg::reset_state_type state;
    supervisor_pkg::reset_state_type next_state;
    logic [RESET_W-1:0] pulse_count;
    logic [RESET_W-1:0] next_pulse_count;
    logic [WD_W-1:0] wd_count;
    logic [WD_W-1:0] next_wd_count;
    logic service_prev;
    logic next_service_prev;
    logic timeout;
    logic next_timeout;
    supervisor_pkg::supervisor_out_type outs;
    supervisor_pkg::supervisor_out_type next_outs;
    logic backup_mode;
    logic service_edge;

    // Gather the analog outcomes; bit 1 of the flag set is backup-above-main
    assign flags_raw.below_threshold = supply_below_threshold_i;
    assign flags_raw.powerfail_below_ref = powerfail_sense_input_i;
    assign flags_raw.backup_higher = backup_supply_input_i;
    assign flags_raw.service_floating = service_floating_i;

    // All pins, the service input among them, pass one synchroniser
    pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .enable_i(clock_enable_i),
        .async_i({flags_raw, watchdog_service_input_i}),
        .sync_o(sync_out)
    );

    assign flags = supervisor_pkg::analog_flags_type'(sync_out[4:1]);
    assign service_sync = sync_out[0];

    // Backup mode: main below threshold and backup supply higher
    assign backup_mode = flags.below_threshold & flags.backup_higher;

    // A level change on the service input; a 50ns pulse spans 2.5 cycles, so it is
    // sampled, but pulses below one period may be missed by any clocked design
    assign service_edge = (service_sync != service_prev);

    // Reset-pulse sequencer
    always_comb begin
        next_state = state;
        next_pulse_count = pulse_count;
        case (state)
            supervisor_pkg::HOLD_LOW: begin
                // Held while supply is low; timer kept at zero
                next_pulse_count = '0;
                if (!flags.below_threshold) begin
                    next_state = supervisor_pkg::TIMING;
                end
            end
            supervisor_pkg::TIMING: begin
                if (flags.below_threshold) begin
                    // Brownout mid-pulse restarts the full interval
                    next_state = supervisor_pkg::HOLD_LOW;
                    next_pulse_count = '0;
                end else if (pulse_count >= RESET_W'(RESET_CYCLES - 1)) begin
                    // Full interval elapsed, release
                    next_state = supervisor_pkg::RELEASED;
                    next_pulse_count = '0;
                end else begin
                    next_pulse_count = pulse_count + RESET_W'(1);
                end
            end
            supervisor_pkg::RELEASED: begin
                next_pulse_count = '0;
                if (flags.below_threshold) begin
                    next_state = supervisor_pkg::HOLD_LOW; // Brownout trigger
                end else if (timeout) begin
                    next_state = supervisor_pkg::TIMING; // Watchdog pulse, full width
                end
            end
            default: begin
                next_state = supervisor_pkg::HOLD_LOW;
                next_pulse_count = '0;
            end
        endcase
    end

    // Watchdog timer
    always_comb begin
        next_service_prev = service_sync;
        next_timeout = 1'b0;
        next_wd_count = wd_count;
        if (state != supervisor_pkg::RELEASED || backup_mode) begin
            // Cleared while reset asserted or in backup mode
            next_wd_count = '0;
        end else if (flags.service_floating) begin
            next_wd_count = '0; // Open input disables the watchdog
        end else if (service_edge) begin
            next_wd_count = '0; // Valid toggle clears the timer
        end else if (wd_count >= WD_W'(WATCHDOG_LIMIT - 1)) begin
            // One-cycle timeout pulse; timer restarts behind the reset pulse
            next_timeout = 1'b1;
            next_wd_count = '0;
        end else begin
            next_wd_count = wd_count + WD_W'(1); // Counting once released and driven
        end
    end

    // Output values, registered so they never glitch
    always_comb begin
        next_outs.reset_n = (next_state == supervisor_pkg::RELEASED) && !backup_mode;
        next_outs.reset = !next_outs.reset_n; // Exact inverse of active-low reset
        // Flag low when sense is below reference or in backup mode
        next_outs.powerfail_flag = !flags.powerfail_below_ref && !backup_mode;
        next_outs.ram_on_backup = backup_mode; // Main supply otherwise
    end

    // State registers; the enable freezes everything
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state <= supervisor_pkg::HOLD_LOW;
            pulse_count <= '0;
            wd_count <= '0;
            service_prev <= 1'b0;
            timeout <= 1'b0;
            outs <= '{reset_n: 1'b0, reset: 1'b1, powerfail_flag: 1'b0, ram_on_backup: 1'b0};
        end else if (clock_enable_i) begin
            state <= next_state;
            pulse_count <= next_pulse_count;
            wd_count <= next_wd_count;
            service_prev <= next_service_prev;
            timeout <= next_timeout;
            outs <= next_outs;
        end
    end

    // Drive ports from registers
    assign reset_n_o = outs.reset_n;
    assign reset_o = outs.reset;
    assign powerfail_flag_output_o = outs.powerfail_flag;
    assign ram_on_backup_o = outs.ram_on_backup;
    assign watchdog_timeout_o = timeout;

endmodule : supply_supervisor_watchdog_reset

// >>> testbench/supervisor_monitor.sv
// Checker for the supervisor block, bound to its top module.
// Counts only enabled cycles, so a frozen enable stretches no interval.
// Assumes inputs that stand 8 cycles have settled through the synchroniser.
`timescale 1ns/1ps
module supervisor_monitor #(
    parameter int unsigned RESET_CYCLES = 20,
    parameter int unsigned WATCHDOG_LIMIT = 50
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clock_enable_i,
    input wire logic supply_below_threshold_i,
    input wire logic powerfail_sense_input_i,
    input wire logic backup_supply_input_i,
    input wire logic service_floating_i,
    input wire logic reset_n_o,
    input wire logic reset_o,
    input wire logic powerfail_flag_output_o,
    input wire logic ram_on_backup_o,
    input wire logic watchdog_timeout_o
);
    default clocking @(posedge clock_i); endclocking
    // A frozen block changes nothing, so checks pause with it
    default disable iff (!resetn_i || !clock_enable_i);
    logic [31:0] low_cnt, next_low_cnt, high_cnt, next_high_cnt;
    // Low run restarts while supply is below, so brownouts measure from recovery
    always_comb begin
        next_low_cnt = (reset_n_o || supply_below_threshold_i) ? 32'h0 : low_cnt + 32'h1;
        next_high_cnt = reset_n_o ? high_cnt + 32'h1 : 32'h0;
    end
    // Run counters advance only on edges the block itself takes
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            low_cnt <= 32'h0;
            high_cnt <= 32'h0;
        end else if (clock_enable_i) begin
            low_cnt <= next_low_cnt;
            high_cnt <= next_high_cnt;
        end
    end
    sequence released_s;
        $rose(reset_n_o);
    endsequence
    sequence expiry_s;
        watchdog_timeout_o ##0 reset_n_o;
    endsequence
    AST_INVERSE: assert property (reset_o == !reset_n_o) else $error("reset outputs not inverse");
    AST_PULSE: assert property (released_s |-> low_cnt >= RESET_CYCLES - 1 && low_cnt <= RESET_CYCLES + 8)
        else $error("reset pulse length wrong");
    AST_BROWNOUT: assert property (supply_below_threshold_i [*8] |-> !reset_n_o) else $error("no reset on brownout");
    AST_WD_TRIG: assert property (expiry_s |-> high_cnt >= WATCHDOG_LIMIT - 1 ##1 !reset_n_o)
        else $error("watchdog expiry wrong");
    AST_WD_QUIET: assert property (!reset_n_o |-> !watchdog_timeout_o) else $error("timeout during reset");
    AST_FLOAT: assert property (service_floating_i [*8] |-> !watchdog_timeout_o) else $error("timeout while open");
    AST_PF_HIGH: assert property ((!supply_below_threshold_i && !powerfail_sense_input_i) [*8] |-> powerfail_flag_output_o)
        else $error("power-fail flag not high");
    AST_PF_LOW: assert property (powerfail_sense_input_i [*8] |-> !powerfail_flag_output_o) else $error("flag not low");
    AST_BACKUP: assert property ((supply_below_threshold_i && backup_supply_input_i) [*8] |->
        !powerfail_flag_output_o && ram_on_backup_o && reset_o) else $error("backup mode outputs wrong");
    AST_RAM_MAIN: assert property ((!supply_below_threshold_i) [*8] |-> !ram_on_backup_o) else $error("RAM not on main");
endmodule : supervisor_monitor
bind supply_supervisor_watchdog_reset supervisor_monitor #(.RESET_CYCLES(RESET_CYCLES), .WATCHDOG_LIMIT(WATCHDOG_LIMIT))
    supervisor_monitor_inst (.*);

// >>> testbench/proc_model.sv
// Supervised processor: toggles the service pin while out of reset.
// Assumes the bench enables or stalls it through kick_en_i.
`timescale 1ns/1ps
module proc_model #(
    parameter int unsigned PERIOD = 16
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic kick_en_i,
    output logic service_o
);
    logic [7:0] cnt = 8'h00;
    initial service_o = 1'b0;
    // Levels held PERIOD cycles, well above the synchroniser filter
    always @(posedge clock_i) begin
        if (!reset_n_i || !kick_en_i) begin
            cnt <= 8'h00;
        end else if (cnt == PERIOD[7:0] - 8'h01) begin
            cnt <= 8'h00;
            service_o <= ~service_o;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : proc_model

// >>> testbench/tb_supply_supervisor_watchdog_reset.sv
// Bench for the supervisor: events noted in a queue, checked by a watcher.
// Assumes short counts of 20 and 50 cycles in place of the real ones.
`timescale 1ns/1ps
module tb_supply_supervisor_watchdog_reset;
    localparam int unsigned RC = 20;
    localparam int unsigned WL = 50;
    logic clock_i, resetn_i, below, pf, bk, flt, kick_en, clk_en;
    logic prev_rn = 1'b0;
    logic svc, reset_n_o, reset_o, pf_o, ram_o, wd_o;
    logic [7:0] rnd = 8'h0B;
    int error_cnt = 0, samples_checked = 0, cycles = 0;
    logic exp_q[$]; // 0 = release, 1 = watchdog expiry
    always #10 clock_i = ~clock_i;
    supply_supervisor_watchdog_reset #(.RESET_CYCLES(RC), .WATCHDOG_LIMIT(WL)) supply_supervisor_watchdog_reset_inst (
        .clock_i(clock_i), .resetn_i(resetn_i), .clock_enable_i(clk_en), .supply_below_threshold_i(below),
        .powerfail_sense_input_i(pf), .backup_supply_input_i(bk), .service_floating_i(flt),
        .watchdog_service_input_i(svc), .reset_n_o(reset_n_o), .reset_o(reset_o),
        .powerfail_flag_output_o(pf_o), .ram_on_backup_o(ram_o), .watchdog_timeout_o(wd_o));
    proc_model proc_model_inst (.clock_i(clock_i), .reset_n_i(reset_n_o), .kick_en_i(kick_en), .service_o(svc));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc
    // Bounded wait until every noted event has been seen
    task automatic wait_idle(input int n);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < n) begin
            cyc(1);
            k++;
        end
        chk("pending_events", 1'b1, exp_q.size() == 0);
    endtask : wait_idle
    task automatic final_report();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    // Watcher: pops the oldest note whenever an event shows; an unnoted event is a fault
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            final_report();
        end else begin
            if (resetn_i && ((reset_n_o === 1'b1 && prev_rn === 1'b0) || wd_o === 1'b1)) begin
                if (exp_q.size() == 0) chk("unexpected_event", 1'b0, 1'b1);
                else chk("event_kind", exp_q.pop_front(), wd_o);
            end
            prev_rn = reset_n_o;
        end
    end
    initial begin
        // Idle levels before the first edge
        clock_i = 1'b0;
        resetn_i <= 1'b0;
        clk_en <= 1'b1;
        below <= 1'b0;
        pf <= 1'b0;
        bk <= 1'b0;
        flt <= 1'b0;
        kick_en <= 1'b0;
        cyc(3);
        resetn_i <= 1;
        kick_en <= 1;
        exp_q.push_back(0);
        wait_idle(200);
        cyc(3 * WL);
        below <= 1;
        cyc(10);
        chk("reset_n", 0, reset_n_o);
        chk("reset", 1, reset_o);
        exp_q.push_back(0);
        below <= 0;
        cyc(RC / 2);
        below <= 1;
        cyc(4);
        below <= 0;
        cyc(RC - 2);
        chk("reset_n_extended", 0, reset_n_o);
        wait_idle(200);
        kick_en <= 0;
        exp_q.push_back(1);
        exp_q.push_back(0);
        wait_idle(WL + RC + 40);
        kick_en <= 1;
        cyc(5);
        kick_en <= 0;
        flt <= 1;
        cyc(2 * WL);
        exp_q.push_back(1);
        exp_q.push_back(0);
        flt <= 0;
        wait_idle(WL + RC + 40);
        kick_en <= 1;
        repeat (8) begin
            rnd = lfsr(rnd);
            pf <= rnd[0];
            bk <= rnd[1];
            cyc(8);
            chk("pf_flag", !rnd[0], pf_o);
            chk("ram_main", 0, ram_o);
        end
        below <= 1;
        bk <= 1;
        pf <= 0;
        cyc(8);
        chk("pf_flag_backup", 0, pf_o);
        chk("ram_backup", 1, ram_o);
        chk("reset_n_backup", 0, reset_n_o);
        chk("reset_backup", 1, reset_o);
        bk <= 0;
        cyc(8);
        chk("ram_main_low", 0, ram_o);
        exp_q.push_back(0);
        below <= 0;
        // Freeze mid-pulse: release would be due well inside this stall
        cyc(RC / 2);
        clk_en <= 0;
        cyc(RC + 10);
        chk("reset_n_frozen", 0, reset_n_o);
        clk_en <= 1;
        wait_idle(200);
        final_report();
    end
endmodule : tb_supply_supervisor_watchdog_reset
